// [core/stk_defines.vh]
// constants for the tick timers and interrupt routing block
`ifndef STK_DEFINES_VH
`define STK_DEFINES_VH

// ============================================================
// sources and routing
`define STK_SRC_N        147
`define STK_SRC_N_8      8'h93
`define STK_WAKE_N       41
`define STK_SMALL_LINES  32
`define STK_SMALL_WAKE_N 8
`define STK_SEL_W        8
`define STK_SEL_RESET    8'hFF

// ============================================================
// tick timer fields
`define STK_TICK_W        24
`define STK_CSR_EN        0
`define STK_CSR_TICK_EN   1
`define STK_CSR_COUNTFLAG 16
`define STK_ICSR_PENDSET  26
`define STK_ICSR_PENDCLR  25
`define STK_SPRIO_W       2
`define STK_LPRIO_W       3
`define STK_RELOAD_RESET  24'h00_0000

// ============================================================
// register byte offsets (8-bit address)
`define STK_OFF_CSR       8'h00
`define STK_OFF_RELOAD    8'h04
`define STK_OFF_CURRENT   8'h08
`define STK_OFF_ICSR      8'h0C
`define STK_OFF_PRIO3     8'h10
`define STK_LARGE_BASE    8'h20
`define STK_OFF_SNMI_SEL  8'h40
`define STK_OFF_LNMI_SEL  8'h44
`define STK_OFF_IRQ_STAT  8'h48
`define STK_OFF_IRQ_MASK  8'h4C
`define STK_OFF_SLEEP     8'h50
`define STK_OFF_ROUTE     8'h80

// ============================================================
// own interrupt status bits
`define STK_EV_W          4
`define STK_EV_STICK      0
`define STK_EV_LTICK      1
`define STK_EV_WAKE       2
`define STK_EV_NMI        3

`endif

// [core/stk_irq_router.v]
// tick timers of both cores and peripheral interrupt routing
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "stk_defines.vh"

// Notes on behaviour
// R1: each core has a 24-bit down-counter
// R2: zero with tick enable raises tick exception
// R3: tick priority 0-3 small, 0-7 large
// R4: pend-set write makes tick pending anytime
// R5: pend-clear write removes tick pending
// R6: all 147 sources map straight to large core
// R7: small core routes any source to 32 lines
// R8: peripheral interrupt is OR of its conditions
// R9: interrupts are levels held until cleared
// R10: only IRQ0-IRQ40 wake from deep sleep
// R11: only small lines 0-7 wake device
// R12: each core's NMI selectable from any source
// R13: IRQ0-16 carry port, all-ports and supply
// R14: IRQ17-24 misc sources, IRQ20 unused
// R15: IRQ25-40 carry the sixteen IPC interrupts
// R16: IRQ41-47 serial blocks, active mode only
// R17: counter reloads at zero and continues
// R18: per-line 8-bit index, combinational follow
module stk_irq_router (
    input  wire                   MCLK,
    input  wire                   RESETN,
    input  wire                   WB_CYC_I,
    input  wire                   WB_STB_I,
    input  wire                   WB_WE_I,
    input  wire [7:0]             WB_ADR_I,
    input  wire [3:0]             WB_SEL_I,
    input  wire [31:0]            WB_DAT_I,
    output wire [31:0]            WB_DAT_O,
    output wire                   WB_ACK_O,
    input  wire [14:0]            GPIO_PORT_IRQ,
    input  wire                   GPIO_SUPPLY_IRQ,
    input  wire                   LP_COMP_IRQ,
    input  wire                   SERIAL8_IRQ,
    input  wire                   MC_WDOG_IRQ,
    input  wire                   RTC_IRQ,
    input  wire                   LOW_VOLT_WDOG_IRQ,
    input  wire                   ANALOG_CT_IRQ,
    input  wire                   RADIO_IRQ,
    input  wire [15:0]            IPC_IRQ,
    input  wire [6:0]             SERIAL_IRQ,
    input  wire [98:0]            UPPER_IRQ,
    input  wire                   DEEP_SLEEP,
    input  wire                   SMALL_TICK_TAKEN,
    input  wire                   LARGE_TICK_TAKEN,
    output wire [146:0]           LARGE_IRQ,
    output wire [31:0]            SMALL_IRQ,
    output wire                   LARGE_NMI,
    output wire                   SMALL_NMI,
    output wire                   SMALL_TICK_EXC,
    output wire                   LARGE_TICK_EXC,
    output wire [1:0]             SMALL_TICK_PRIO,
    output wire [2:0]             LARGE_TICK_PRIO,
    output wire                   WAKEUP,
    output wire                   IRQ_O
);

// ============================================================
// helpers
function sel_src;
    input [146:0] vec;
    input [7:0]   idx;
    begin
        // out-of-range index means unrouted
        if (idx < `STK_SRC_N_8) begin
            sel_src = vec[idx];
        end else begin
            sel_src = 1'b0;
        end
    end
endfunction

function [31:0] lane_mask;
    input [3:0] sel;
    begin
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
endfunction

// ============================================================
// source vector
wire [146:0] src;
wire [146:0] src_g;

assign src[14:0]    = GPIO_PORT_IRQ;                               // [R13]
assign src[15]      = |GPIO_PORT_IRQ;                              // [R8] [R13]
assign src[16]      = GPIO_SUPPLY_IRQ;                             // [R13]
assign src[17]      = LP_COMP_IRQ;                                 // [R14]
assign src[18]      = SERIAL8_IRQ;                                 // [R14]
assign src[19]      = MC_WDOG_IRQ;                                 // [R14]
assign src[20]      = 1'b0;                                        // [R14]
assign src[21]      = RTC_IRQ;                                     // [R14]
assign src[22]      = LOW_VOLT_WDOG_IRQ;                           // [R14]
assign src[23]      = ANALOG_CT_IRQ;                               // [R14]
assign src[24]      = RADIO_IRQ;                                   // [R14]
assign src[40:25]   = IPC_IRQ;                                     // [R15]
assign src[47:41]   = SERIAL_IRQ;                                  // [R16]
assign src[146:48]  = UPPER_IRQ;

// levels pass untouched; a source stays up until its owner clears it
// above the wake group nothing runs in deep sleep
assign src_g = DEEP_SLEEP ? {106'h0, src[40:0]} : src;             // [R9] [R10] [R16]

assign LARGE_IRQ = src_g;                                          // [R6]

// ============================================================
// bus front end
reg         ack_r;
reg  [31:0] dat_r;
reg         region_r;
wire        acc     = WB_CYC_I & WB_STB_I & ~ack_r;
wire        wr      = acc & WB_WE_I;
wire        rd      = acc & ~WB_WE_I;
wire [31:0] wmask   = lane_mask(WB_SEL_I);
wire [31:0] wbits   = WB_DAT_I & wmask;
wire        tick_rg = (WB_ADR_I[7:6] == 2'b00);
wire        tk      = WB_ADR_I[5];
wire [7:0]  toff    = {3'b000, WB_ADR_I[4:0]};
wire        route_rg = WB_ADR_I[7];

// ============================================================
// tick state, index 0 small core, 1 large core
reg  [1:0]                en_r;
reg  [1:0]                tint_r;
reg  [1:0]                cflag_r;
reg  [1:0]                pend_r;
reg  [`STK_TICK_W-1:0]    reload_r [0:1];
reg  [`STK_SPRIO_W-1:0]   sprio_r;
reg  [`STK_LPRIO_W-1:0]   lprio_r;
wire [`STK_TICK_W-1:0]    count [0:1];
wire [1:0]                zero;
wire [1:0]                clr_cur;
wire [1:0]                taken = {LARGE_TICK_TAKEN, SMALL_TICK_TAKEN};

genvar k;
generate
    for (k = 0; k < 2; k = k + 1) begin : g_tick
        assign clr_cur[k] = wr & tick_rg & (tk == k) & (toff == `STK_OFF_CURRENT);
        stk_tick_timer u_tick (
            .clk        (MCLK),
            .rst_n      (RESETN),
            .enable     (en_r[k]),
            .clear_cur  (clr_cur[k]),
            .reload     (reload_r[k]),
            .count      (count[k]),
            .zero_pulse (zero[k])
        );
    end
endgenerate

// ============================================================
// nmi and routing state
reg  [7:0]   snmi_sel_r;
reg  [7:0]   lnmi_sel_r;
wire [255:0] route_q;
wire [7:0]   route_rdata;
wire         route_we = wr & route_rg & WB_SEL_I[0];

stk_route_mem u_route (
    .clk   (MCLK),
    .rst_n (RESETN),
    .we    (route_we),
    .waddr (WB_ADR_I[6:2]),
    .wdata (WB_DAT_I[7:0]),
    .raddr (WB_ADR_I[6:2]),
    .rdata (route_rdata),
    .all_q (route_q)
);

genvar j;
generate
    for (j = 0; j < `STK_SMALL_LINES; j = j + 1) begin : g_line
        wire raw = sel_src(src_g, route_q[j*8 +: 8]);             // [R7] [R18]
        if (j < `STK_SMALL_WAKE_N) begin : g_wake
            assign SMALL_IRQ[j] = raw;                             // [R11]
        end else begin : g_act
            assign SMALL_IRQ[j] = raw & ~DEEP_SLEEP;               // [R11]
        end
    end
endgenerate

assign SMALL_NMI = sel_src(src_g, snmi_sel_r);                     // [R12]
assign LARGE_NMI = sel_src(src_g, lnmi_sel_r);                     // [R12]

assign WAKEUP = DEEP_SLEEP & ((|src[`STK_WAKE_N-1:0]) |            // [R10]
                (|SMALL_IRQ[`STK_SMALL_WAKE_N-1:0]));              // [R11]

// ============================================================
// own interrupt status
reg  [`STK_EV_W-1:0] istat_r;
reg  [`STK_EV_W-1:0] imask_r;
reg                  wake_d_r;
reg                  nmi_d_r;
wire                 nmi_any = SMALL_NMI | LARGE_NMI;
wire [`STK_EV_W-1:0] ev = {nmi_any & ~nmi_d_r, WAKEUP & ~wake_d_r, zero[1], zero[0]};
wire                 stat_w = wr & (WB_ADR_I == `STK_OFF_IRQ_STAT);
wire [`STK_EV_W-1:0] istat_nxt = ev | (istat_r & ~(stat_w ? wbits[`STK_EV_W-1:0] : 4'h0));

assign IRQ_O = |(istat_r & imask_r);

// ============================================================
// read mux
reg [31:0] rd_val;

always @* begin
    rd_val = 32'h0000_0000;
    if (tick_rg) begin
        if (toff == `STK_OFF_CSR) begin
            rd_val[`STK_CSR_EN]        = en_r[tk];
            rd_val[`STK_CSR_TICK_EN]   = tint_r[tk];
            rd_val[`STK_CSR_COUNTFLAG] = cflag_r[tk];
        end else if (toff == `STK_OFF_RELOAD) begin
            rd_val[`STK_TICK_W-1:0] = reload_r[tk];
        end else if (toff == `STK_OFF_CURRENT) begin
            rd_val[`STK_TICK_W-1:0] = count[tk];
        end else if (toff == `STK_OFF_ICSR) begin
            rd_val[`STK_ICSR_PENDSET] = pend_r[tk];
        end else if (toff == `STK_OFF_PRIO3) begin
            if (tk) begin
                rd_val[31:29] = lprio_r;
            end else begin
                rd_val[31:30] = sprio_r;
            end
        end
    end else if (WB_ADR_I == `STK_OFF_SNMI_SEL) begin
        rd_val[7:0] = snmi_sel_r;
    end else if (WB_ADR_I == `STK_OFF_LNMI_SEL) begin
        rd_val[7:0] = lnmi_sel_r;
    end else if (WB_ADR_I == `STK_OFF_IRQ_STAT) begin
        rd_val[`STK_EV_W-1:0] = istat_r;
    end else if (WB_ADR_I == `STK_OFF_IRQ_MASK) begin
        rd_val[`STK_EV_W-1:0] = imask_r;
    end else if (WB_ADR_I == `STK_OFF_SLEEP) begin
        rd_val[1:0] = {WAKEUP, DEEP_SLEEP};
    end
end

wire [31:0] merged = (rd_val & ~wmask) | wbits;

// ============================================================
// register updates
integer n;

always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
        ack_r       <= 1'b0;
        dat_r       <= 32'h0000_0000;
        region_r    <= 1'b0;
        en_r        <= 2'b00;
        tint_r      <= 2'b00;
        cflag_r     <= 2'b00;
        pend_r      <= 2'b00;
        reload_r[0] <= `STK_RELOAD_RESET;
        reload_r[1] <= `STK_RELOAD_RESET;
        sprio_r     <= 2'b00;
        lprio_r     <= 3'b000;
        snmi_sel_r  <= `STK_SEL_RESET;
        lnmi_sel_r  <= `STK_SEL_RESET;
        istat_r     <= 4'h0;
        imask_r     <= 4'h0;
        wake_d_r    <= 1'b0;
        nmi_d_r     <= 1'b0;
    end else begin
        ack_r    <= acc;
        wake_d_r <= WAKEUP;
        nmi_d_r  <= nmi_any;
        istat_r  <= istat_nxt;
        if (acc) begin
            dat_r    <= rd_val;
            region_r <= route_rg;
        end
        for (n = 0; n < 2; n = n + 1) begin
            // a count reaching zero in the same cycle beats the read-clear
            if (zero[n]) begin
                cflag_r[n] <= 1'b1;
            end else if (rd && tick_rg && tk == n && toff == `STK_OFF_CSR) begin
                cflag_r[n] <= 1'b0;
            end
            // any set source wins over a clear in the same cycle
            if ((zero[n] & tint_r[n]) |                            // [R2]
                (wr && tick_rg && tk == n && toff == `STK_OFF_ICSR &&
                 wbits[`STK_ICSR_PENDSET])) begin                  // [R4]
                pend_r[n] <= 1'b1;
            end else if (taken[n] |
                (wr && tick_rg && tk == n && toff == `STK_OFF_ICSR &&
                 wbits[`STK_ICSR_PENDCLR])) begin                  // [R5]
                pend_r[n] <= 1'b0;
            end
        end
        if (wr) begin
            if (tick_rg) begin
                if (toff == `STK_OFF_CSR) begin
                    en_r[tk]   <= merged[`STK_CSR_EN];
                    tint_r[tk] <= merged[`STK_CSR_TICK_EN];
                end else if (toff == `STK_OFF_RELOAD) begin
                    reload_r[tk] <= merged[`STK_TICK_W-1:0];
                end else if (toff == `STK_OFF_PRIO3) begin
                    // field width alone limits the accepted range
                    if (tk) begin
                        lprio_r <= merged[31:29];                  // [R3]
                    end else begin
                        sprio_r <= merged[31:30];                  // [R3]
                    end
                end
            end else if (WB_ADR_I == `STK_OFF_SNMI_SEL) begin
                snmi_sel_r <= merged[7:0];
            end else if (WB_ADR_I == `STK_OFF_LNMI_SEL) begin
                lnmi_sel_r <= merged[7:0];
            end else if (WB_ADR_I == `STK_OFF_IRQ_MASK) begin
                imask_r <= merged[`STK_EV_W-1:0];
            end
        end
    end
end

// ============================================================
// outputs
assign WB_ACK_O        = ack_r;
assign WB_DAT_O        = region_r ? {24'h00_0000, route_rdata} : dat_r;
assign SMALL_TICK_EXC  = pend_r[0];                                // [R2]
assign LARGE_TICK_EXC  = pend_r[1];                                // [R2]
assign SMALL_TICK_PRIO = sprio_r;
assign LARGE_TICK_PRIO = lprio_r;

endmodule // stk_irq_router

// [core/stk_route_mem.v]
// table of source indices for the small core's routed lines
`timescale 1ns/1ps
`include "stk_defines.vh"
module stk_route_mem (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   we,
    input  wire [4:0]             waddr,
    input  wire [7:0]             wdata,
    input  wire [4:0]             raddr,
    output reg  [7:0]             rdata,
    output wire [255:0]           all_q
);

reg [7:0] mem [0:31];
integer   i;

// ============================================================
// storage, reset to unrouted
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        for (i = 0; i < 32; i = i + 1) begin
            mem[i] <= `STK_SEL_RESET;
        end
        rdata <= 8'h00;
    end else begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
end

// every entry is visible at once for the line muxes
genvar g;
generate
    for (g = 0; g < 32; g = g + 1) begin : g_flat
        assign all_q[g*8 +: 8] = mem[g];                          // [R18]
    end
endgenerate

endmodule // stk_route_mem

// [core/stk_tick_timer.v]
// 24-bit reload down-counter for one core's tick
`timescale 1ns/1ps
module stk_tick_timer (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   enable,
    input  wire                   clear_cur,
    input  wire [23:0]            reload,
    output reg  [23:0]            count,
    output reg                    zero_pulse
);

// ============================================================
// counter
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        count      <= 24'h00_0000;
        zero_pulse <= 1'b0;
    end else begin
        zero_pulse <= 1'b0;
        if (clear_cur) begin
            count <= 24'h00_0000;
        end else if (enable) begin
            if (count == 24'h00_0000) begin
                // reload zero parks the counter with no events
                count <= reload;                                  // [R17]
            end else begin
                count <= count - 24'h00_0001;                     // [R1]
                if (count == 24'h00_0001) begin
                    zero_pulse <= 1'b1;
                end
            end
        end
    end
end

endmodule // stk_tick_timer

// [verification/stk_core_model.sv]
// core-side model that accepts a pending tick exception
`timescale 1ns/1ps
module stk_core_model (
    input  wire  clk,
    input  wire  rst_n,
    input  wire  hold,
    input  wire  exc,
    output logic taken
);
    // ============================================================
    // handler entry: one accept pulse per pending level seen
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            taken <= 1'b0;
        else
            taken <= exc && !taken && !hold;
    end
endmodule // stk_core_model

// [verification/stk_router_sva.sv]
// checker for bus timing, source mapping and tick pending rules
`timescale 1ns/1ps
module stk_router_sva (
    input wire         MCLK,
    input wire         RESETN,
    input wire         WB_CYC_I,
    input wire         WB_STB_I,
    input wire         WB_WE_I,
    input wire [7:0]   WB_ADR_I,
    input wire [3:0]   WB_SEL_I,
    input wire [31:0]  WB_DAT_I,
    input wire         WB_ACK_O,
    input wire [14:0]  GPIO_PORT_IRQ,
    input wire         GPIO_SUPPLY_IRQ,
    input wire         LP_COMP_IRQ,
    input wire         SERIAL8_IRQ,
    input wire         MC_WDOG_IRQ,
    input wire         RTC_IRQ,
    input wire         LOW_VOLT_WDOG_IRQ,
    input wire         ANALOG_CT_IRQ,
    input wire         RADIO_IRQ,
    input wire [15:0]  IPC_IRQ,
    input wire [6:0]   SERIAL_IRQ,
    input wire [98:0]  UPPER_IRQ,
    input wire         DEEP_SLEEP,
    input wire         SMALL_TICK_TAKEN,
    input wire [146:0] LARGE_IRQ,
    input wire [31:0]  SMALL_IRQ,
    input wire         SMALL_TICK_EXC,
    input wire         WAKEUP
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // ============================================================
    // helpers
    wire icsr_wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h0C && WB_SEL_I[3];
    // ============================================================
    // assertions
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    ack_in_time_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    low_map_a: assert property (LARGE_IRQ[40:0] == {IPC_IRQ, RADIO_IRQ, ANALOG_CT_IRQ, LOW_VOLT_WDOG_IRQ,
        RTC_IRQ, 1'b0, MC_WDOG_IRQ, SERIAL8_IRQ, LP_COMP_IRQ, GPIO_SUPPLY_IRQ, |GPIO_PORT_IRQ, GPIO_PORT_IRQ})
        else $error("low source map wrong");
    high_map_a: assert property (!DEEP_SLEEP |-> LARGE_IRQ[146:41] == {UPPER_IRQ, SERIAL_IRQ})
        else $error("high source map wrong");
    sleep_gate_a: assert property (DEEP_SLEEP |-> LARGE_IRQ[146:41] == 106'h0 && SMALL_IRQ[31:8] == 24'h0)
        else $error("non-wake source active in sleep");
    wake_level_a: assert property (WAKEUP == (DEEP_SLEEP && (|LARGE_IRQ[40:0] || |SMALL_IRQ[7:0])))
        else $error("wakeup level wrong");
    pend_set_a: assert property (icsr_wr && WB_DAT_I[26] |=> SMALL_TICK_EXC) else $error("pend set ignored");
    pend_clr_a: assert property (icsr_wr && WB_DAT_I[25] && !WB_DAT_I[26] |=> !SMALL_TICK_EXC)
        else $error("pend clear ignored");
    exc_hold_a: assert property ($fell(SMALL_TICK_EXC) |-> $past(SMALL_TICK_TAKEN) || $past(icsr_wr))
        else $error("tick pending dropped by itself");
endmodule // stk_router_sva

bind stk_irq_router stk_router_sva i_stk_router_sva (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .GPIO_PORT_IRQ(GPIO_PORT_IRQ), .GPIO_SUPPLY_IRQ(GPIO_SUPPLY_IRQ),
    .LP_COMP_IRQ(LP_COMP_IRQ), .SERIAL8_IRQ(SERIAL8_IRQ), .MC_WDOG_IRQ(MC_WDOG_IRQ), .RTC_IRQ(RTC_IRQ),
    .LOW_VOLT_WDOG_IRQ(LOW_VOLT_WDOG_IRQ), .ANALOG_CT_IRQ(ANALOG_CT_IRQ), .RADIO_IRQ(RADIO_IRQ),
    .IPC_IRQ(IPC_IRQ), .SERIAL_IRQ(SERIAL_IRQ), .UPPER_IRQ(UPPER_IRQ), .DEEP_SLEEP(DEEP_SLEEP),
    .SMALL_TICK_TAKEN(SMALL_TICK_TAKEN), .LARGE_IRQ(LARGE_IRQ), .SMALL_IRQ(SMALL_IRQ),
    .SMALL_TICK_EXC(SMALL_TICK_EXC), .WAKEUP(WAKEUP));

// [verification/tb_top.sv]
// self-checking bench for the tick timers and interrupt routing
`timescale 1ns/1ps
module tb_top;
    // ============================================================
    // signals
    logic         mclk, resetn, cyc, stb, we, deep, hold;
    logic [7:0]   adr;
    logic [3:0]   sel;
    logic [31:0]  dat_i, dat_o, rd, sm_irq;
    logic         ack, s_take, l_take, s_exc, l_exc, s_nmi, l_nmi, wake, irq;
    logic [144:0] pin;
    logic [146:0] lg_irq, exp;
    logic [1:0]   s_prio;
    logic [2:0]   l_prio;
    int           n_mismatch, comparisons, gap, k;
    // pin index beside the system line it must reach
    int           rows [16][2] = '{'{0, 0}, '{14, 14}, '{15, 16}, '{16, 17}, '{17, 18}, '{18, 19}, '{19, 21},
        '{20, 22}, '{21, 23}, '{22, 24}, '{23, 25}, '{38, 40}, '{39, 41}, '{45, 47}, '{46, 48}, '{144, 146}};

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    stk_irq_router i_stk_irq_router (.MCLK(mclk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .GPIO_PORT_IRQ(pin[14:0]), .GPIO_SUPPLY_IRQ(pin[15]), .LP_COMP_IRQ(pin[16]), .SERIAL8_IRQ(pin[17]),
        .MC_WDOG_IRQ(pin[18]), .RTC_IRQ(pin[19]), .LOW_VOLT_WDOG_IRQ(pin[20]), .ANALOG_CT_IRQ(pin[21]),
        .RADIO_IRQ(pin[22]), .IPC_IRQ(pin[38:23]), .SERIAL_IRQ(pin[45:39]), .UPPER_IRQ(pin[144:46]),
        .DEEP_SLEEP(deep), .SMALL_TICK_TAKEN(s_take), .LARGE_TICK_TAKEN(l_take), .LARGE_IRQ(lg_irq),
        .SMALL_IRQ(sm_irq), .LARGE_NMI(l_nmi), .SMALL_NMI(s_nmi), .SMALL_TICK_EXC(s_exc),
        .LARGE_TICK_EXC(l_exc), .SMALL_TICK_PRIO(s_prio), .LARGE_TICK_PRIO(l_prio), .WAKEUP(wake), .IRQ_O(irq));
    stk_core_model i_stk_core_small (.clk(mclk), .rst_n(resetn), .hold(hold), .exc(s_exc), .taken(s_take));
    stk_core_model i_stk_core_large (.clk(mclk), .rst_n(resetn), .hold(hold), .exc(l_exc), .taken(l_take));

    // ============================================================
    // tasks
    task give_verdict;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [146:0] e, input logic [146:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; a missing ack ends the run
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= d; sel <= s;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge mclk);
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("ERROR wb ack expected 1 seen %b", ack);
            give_verdict;
        end
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // ============================================================
    // sequence
    initial begin
        resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dat_i = 32'h0;
        pin = 145'h0; deep = 1'b0; hold = 1'b0; n_mismatch = 0; comparisons = 0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        for (int r = 0; r < 16; r++) begin
            wb(1'b1, 8'h80 + 8'(4 * r), 32'(rows[r][1]), 4'h1);
            wb(1'b1, 8'h40, 32'(rows[r][1]), 4'hF);
            wb(1'b1, 8'h44, 32'(rows[r][1]), 4'hF);
            @(posedge mclk);
            pin <= 145'h1 << rows[r][0];
            @(negedge mclk);
            exp = 147'h1 << rows[r][1];
            if (rows[r][1] < 15) exp[15] = 1'b1;
            chk("large", exp, lg_irq);
            chk("small", 147'(32'h1 << r), 147'(sm_irq));
            chk("nmi", 147'h3, {145'h0, s_nmi, l_nmi});
        end
        // sticky status, mask and clear by writing one
        wb(1'b0, 8'h48, 32'h0, 4'hF);
        chk("status", 147'h8, 147'(rd));
        chk("irq", 147'h0, 147'(irq));
        wb(1'b1, 8'h4C, 32'h8, 4'hF);
        @(negedge mclk);
        chk("irq", 147'h1, 147'(irq));
        wb(1'b1, 8'h48, 32'h8, 4'hF);
        @(negedge mclk);
        chk("irq", 147'h0, 147'(irq));
        // deep sleep keeps only wake sources and small lines 0 to 7
        @(posedge mclk);
        deep <= 1'b1;
        pin <= (145'h1 << 20) | (145'h1 << 38) | (145'h1 << 39);
        @(negedge mclk);
        chk("sleep large", (147'h1 << 22) | (147'h1 << 40), lg_irq);
        chk("sleep small", 147'h80, 147'(sm_irq));
        chk("wake", 147'h1, 147'(wake));
        @(posedge mclk);
        pin <= 145'h1 << 39;
        @(negedge mclk);
        chk("no wake", 147'h0, lg_irq | 147'(sm_irq) | 147'(wake));
        wb(1'b0, 8'h48, 32'h0, 4'hF);
        chk("status", 147'h4, 147'(rd));
        deep <= 1'b0;
        // priority fields keep their widths
        wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        wb(1'b1, 8'h30, 32'hFFFF_FFFF, 4'hF);
        @(negedge mclk);
        chk("prio", 147'h1F, {142'h0, s_prio, l_prio});
        wb(1'b1, 8'h10, 32'h4000_0000, 4'hF);
        wb(1'b1, 8'h30, 32'hA000_0000, 4'hF);
        @(negedge mclk);
        chk("prio", 147'hD, {142'h0, s_prio, l_prio});
        wb(1'b1, 8'h04, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, 8'h04, 32'h0, 4'hF);
        chk("reload", 147'hFF_FFFF, 147'(rd));
        // reload 2 gives a pending tick every 3 cycles
        wb(1'b1, 8'h04, 32'h2, 4'hF);
        wb(1'b1, 8'h08, 32'h0, 4'hF);
        wb(1'b1, 8'h00, 32'h3, 4'hF);
        for (k = 0; k < 50 && s_exc !== 1'b1; k++) @(posedge mclk);
        gap = 0;
        while (gap < 50 && s_exc !== 1'b0) begin
            @(posedge mclk);
            gap++;
        end
        while (gap < 50 && s_exc !== 1'b1) begin
            @(posedge mclk);
            gap++;
        end
        chk("period", 147'h3, 147'(gap));
        // software pend set holds until software clear, or until core accept once hold drops
        hold <= 1'b1;
        wb(1'b1, 8'h00, 32'h0, 4'hF);
        wb(1'b1, 8'h0C, 32'h0400_0000, 4'hF);
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        chk("held", 147'h1, 147'(s_exc));
        wb(1'b1, 8'h0C, 32'h0200_0000, 4'hF);
        @(negedge mclk);
        chk("cleared", 147'h0, 147'(s_exc));
        wb(1'b1, 8'h2C, 32'h0400_0000, 4'hF);
        @(negedge mclk);
        chk("large set", 147'h1, 147'(l_exc));
        hold <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("large taken", 147'h0, 147'(l_exc));
        // second reset in mid-run
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        wb(1'b0, 8'h80, 32'h0, 4'hF);
        chk("route reset", 147'hFF, 147'(rd));
        wb(1'b0, 8'h60, 32'h0, 4'hF);
        chk("unmapped", 147'h0, 147'(rd));
        chk("reset outs", 147'h0, 147'({s_exc, l_exc, s_prio, l_prio, irq}));
        give_verdict;
    end
endmodule // tb_top
